// ===== safcr_regs.sv
// register bank: statistic readout, fundamental-frequency preload,
// flash update counter and six pages of fir coefficients
//
// Function
// - z statistic register shows the z metric picked by the pointer.
// - pointer low byte 0,4,5,6: result in axis sample-buffer format.
// - pointer low byte 1,2,3: result in fixed-point integer/fraction form.
// - fixed point: integer in upper byte, fraction lower byte, 1/256 step.
// - fundamental frequency 16 bits, 1 Hz steps; zero leaves alarms alone.
// - writing its upper byte loads all alarm band edges and levels.
// - edges 0.2..10.2 times fundamental, last stop FMAX_DHZ; levels 0.5 g and set percents.
// - 32-bit flash update count read as low and high words.
// - each filter has 32 taps of 16-bit signed coefficients.
// - banks sit on pages one to six, chosen by the page register.
// - factory default banks: low-pass then high-pass at 1, 5, 10 kHz.
// - host may write every coefficient; contents may be kept in flash.
// - filter control enables filtering and picks the active bank.
// - default coefficient sets are symmetric, giving linear phase.
// - pointer low three bits: mean, sdev, peak, p-p, crest, kurt, skew.
`timescale 1ns/1ps
`default_nettype none
`include "safcr_cfg.svh"

module safcr_regs #(
  parameter int FIX_W = 24,
  parameter int FMAX_DHZ = 1100000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din_valid,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  output logic [2:0] stat_metric_sel,
  input wire logic [63:0] y_stat_samples,
  input wire logic [3*FIX_W-1:0] y_stat_fixed,
  input wire logic [63:0] z_stat_samples,
  input wire logic [3*FIX_W-1:0] z_stat_fixed,
  input wire logic flash_update_pulse,
  output logic alarm_load,
  output logic [6*24-1:0] band_start_dhz,
  output logic [6*24-1:0] band_stop_dhz,
  output logic [6*16-1:0] alarm1_level_mg,
  output logic [6*16-1:0] alarm2_level_mg,
  output logic fir_enable,
  output logic [2:0] fir_bank,
  input wire logic [4:0] coef_rd_tap,
  output logic [15:0] coef_rd_data,
  output logic [15:0] flash_fundamental_frequency,
  output logic [15:0] flash_filter_control
);

  initial begin
    if (FMAX_DHZ < 1 || FMAX_DHZ > 24'hffffff) begin
      $error("safcr_regs: FMAX_DHZ does not fit a 24-bit band edge");
    end
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire logic wr = din_valid & din[`SAFCR_DIN_WR_BIT];
  wire logic rd = din_valid & ~din[`SAFCR_DIN_WR_BIT];
  wire logic [6:0] addr = din[14:8];
  wire logic [7:0] wbyte = din[7:0];
  wire logic hi_byte = addr[0];
  wire logic [5:0] widx = addr[6:1];

  logic [7:0] page_r;
  wire logic on_main = (page_r == `SAFCR_PAGE_MAIN);
  wire logic on_bank = (page_r >= `SAFCR_PAGE_BANK_FIRST) &&
                       (page_r <= `SAFCR_PAGE_BANK_LAST);
  wire logic [2:0] page_bank = 3'(page_r[2:0] - 3'h1);

  function automatic logic hit(input logic [6:0] a, input logic [6:0] base);
    hit = (a[6:1] == base[6:1]);
  endfunction : hit

  wire logic hit_page = hit(addr, `SAFCR_ADDR_PAGE);
  wire logic hit_fctl = on_main & hit(addr, `SAFCR_ADDR_FILTER_CONTROL);
  wire logic hit_sptr = on_main & hit(addr, `SAFCR_ADDR_STAT_PTR);
  wire logic hit_ystat = on_main & hit(addr, `SAFCR_ADDR_Y_STAT);
  wire logic hit_zstat = on_main & hit(addr, `SAFCR_ADDR_Z_STAT);
  wire logic hit_ffreq = on_main & hit(addr, `SAFCR_ADDR_FUNDAMENTAL_FREQUENCY);
  wire logic hit_cntlo = on_main & hit(addr, `SAFCR_ADDR_FCNT_LO);
  wire logic hit_cnthi = on_main & hit(addr, `SAFCR_ADDR_FCNT_HI);
  wire logic [5:0] coef_widx = 6'(widx - 6'(`SAFCR_ADDR_COEF0 >> 1));
  wire logic hit_coef = on_bank && (widx >= 6'(`SAFCR_ADDR_COEF0 >> 1)) &&
                        (coef_widx < 6'd32);
  wire logic [4:0] coef_tap = coef_widx[4:0];

  // ----------------------------------------------------------------
  // writable registers; read-only ones have no write path
  // ----------------------------------------------------------------
  logic [15:0] fctl_r;
  logic [15:0] sptr_r;
  logic [15:0] ffreq_r;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic h, input logic [7:0] b);
    merge = h ? {b, old[7:0]} : {old[15:8], b};
  endfunction : merge

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_r <= `SAFCR_RST_PAGE;
      fctl_r <= `SAFCR_RST_FILTER_CONTROL;
      sptr_r <= `SAFCR_RST_STAT_PTR;
      ffreq_r <= `SAFCR_RST_FUNDAMENTAL_FREQUENCY;
    end else if (wr) begin
      if (hit_page && !hi_byte) begin
        page_r <= wbyte;
      end
      if (hit_fctl) begin
        fctl_r <= merge(fctl_r, hi_byte, wbyte);
      end
      if (hit_sptr) begin
        sptr_r <= merge(sptr_r, hi_byte, wbyte);
      end
      if (hit_ffreq) begin
        ffreq_r <= merge(ffreq_r, hi_byte, wbyte);
      end
    end
  end

  assign stat_metric_sel = sptr_r[2:0];
  assign fir_bank = fctl_r[`SAFCR_FCTL_BANK_LSB +: 3];
  assign fir_enable = fctl_r[`SAFCR_FCTL_EN_BIT] &&
                      (fir_bank >= 3'h1) && (fir_bank <= 3'h6);
  assign flash_fundamental_frequency = ffreq_r;
  assign flash_filter_control = fctl_r;

  // ----------------------------------------------------------------
  // statistic results
  // ----------------------------------------------------------------
  logic [15:0] y_fmt;
  logic [15:0] z_fmt;
  logic [15:0] ystat_r;
  logic [15:0] zstat_r;

  safcr_stat_fmt #(.FIX_W(FIX_W)) u_fmt_y (
    .ptr_lo(sptr_r[7:0]),
    .sample_words(y_stat_samples),
    .fixed_vals(y_stat_fixed),
    .result(y_fmt)
  );

  safcr_stat_fmt #(.FIX_W(FIX_W)) u_fmt_z (
    .ptr_lo(sptr_r[7:0]),
    .sample_words(z_stat_samples),
    .fixed_vals(z_stat_fixed),
    .result(z_fmt)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ystat_r <= `SAFCR_RST_STAT;
      zstat_r <= `SAFCR_RST_STAT;
    end else begin
      ystat_r <= y_fmt;
      zstat_r <= z_fmt;
    end
  end

  // ----------------------------------------------------------------
  // flash update counter
  // ----------------------------------------------------------------
  logic [31:0] fcnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_r <= `SAFCR_RST_FCNT;
    end else if (flash_update_pulse) begin
      fcnt_r <= fcnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // alarm band preload
  // ----------------------------------------------------------------
  localparam int EDGE [6] = '{`SAFCR_EDGE_0, `SAFCR_EDGE_1, `SAFCR_EDGE_2,
                              `SAFCR_EDGE_3, `SAFCR_EDGE_4, `SAFCR_EDGE_5};
  localparam int PCT [6] = '{`SAFCR_ALM1_PCT_0, `SAFCR_ALM1_PCT_1,
                             `SAFCR_ALM1_PCT_2, `SAFCR_ALM1_PCT_3,
                             `SAFCR_ALM1_PCT_4, `SAFCR_ALM1_PCT_5};

  // the new value includes the upper byte written in this cycle
  wire logic [15:0] ffreq_new = {wbyte, ffreq_r[7:0]};
  wire logic load_go = wr && hit_ffreq && hi_byte &&
                       (ffreq_new != 16'h0000);
  logic load_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_r <= 1'b0;
    end else begin
      load_r <= load_go;
    end
  end

  assign alarm_load = load_r;

  for (genvar i = 0; i < 6; i++) begin : g_band
    localparam logic [23:0] STOP_M = 24'(EDGE[(i < 5) ? i + 1 : 5]);
    localparam logic [15:0] LVL1 = 16'(`SAFCR_ALM2_MG * PCT[i] / 100);
    logic [23:0] start_r;
    logic [23:0] stop_r;
    logic [15:0] lvl1_r;
    logic [15:0] lvl2_r;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        start_r <= 24'h0;
        stop_r <= 24'h0;
        lvl1_r <= 16'h0;
        lvl2_r <= 16'h0;
      end else if (load_go) begin
        start_r <= 24'({8'h0, ffreq_new} * 24'(EDGE[i]));
        stop_r <= (i < 5) ? 24'({8'h0, ffreq_new} * STOP_M) :
                  24'(FMAX_DHZ);
        lvl1_r <= LVL1;
        lvl2_r <= 16'(`SAFCR_ALM2_MG);
      end
    end

    assign band_start_dhz[i*24 +: 24] = start_r;
    assign band_stop_dhz[i*24 +: 24] = stop_r;
    assign alarm1_level_mg[i*16 +: 16] = lvl1_r;
    assign alarm2_level_mg[i*16 +: 16] = lvl2_r;
  end

  // ----------------------------------------------------------------
  // fir coefficient banks with factory defaults
  // ----------------------------------------------------------------
  // half tables mirrored about the centre: symmetric taps, linear phase
  localparam logic [15:0] DEF_HALF [6][16] = '{
    '{16'h03e0, 16'h03e8, 16'h03f0, 16'h03f8, 16'h0400, 16'h0404,
      16'h0408, 16'h040c, 16'h0410, 16'h0414, 16'h0418, 16'h041c,
      16'h0420, 16'h0424, 16'h0428, 16'h042c},
    '{16'h0080, 16'h0100, 16'h01c0, 16'h0280, 16'h0340, 16'h0400,
      16'h04c0, 16'h0580, 16'h0640, 16'h0700, 16'h07a0, 16'h0820,
      16'h0880, 16'h08c0, 16'h08f0, 16'h0900},
    '{16'hffc0, 16'hff80, 16'hff80, 16'h0000, 16'h0080, 16'h0100,
      16'h0100, 16'h0080, 16'h0000, 16'hff00, 16'hff80, 16'h0200,
      16'h0600, 16'h0a00, 16'h0e00, 16'h1000},
    '{16'hfc20, 16'hfc18, 16'hfc10, 16'hfc08, 16'hfc00, 16'hfbfc,
      16'hfbf8, 16'hfbf4, 16'hfbf0, 16'hfbec, 16'hfbe8, 16'hfbe4,
      16'hfbe0, 16'hfbdc, 16'hfbd8, 16'h3c00},
    '{16'hff80, 16'hff00, 16'hfe40, 16'hfd80, 16'hfcc0, 16'hfc00,
      16'hfb40, 16'hfa80, 16'hf9c0, 16'hf900, 16'hf860, 16'hf7e0,
      16'hf780, 16'hf740, 16'hf710, 16'h3000},
    '{16'h0040, 16'h0080, 16'h0080, 16'h0000, 16'hff80, 16'hff00,
      16'hff00, 16'hff80, 16'h0000, 16'h0100, 16'h0080, 16'hfe00,
      16'hfa00, 16'hf600, 16'hf200, 16'h3000}
  };

  safcr_pkg::safcr_coef_t coef_r [6][32];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < 6; b++) begin
        for (int t = 0; t < 32; t++) begin
          coef_r[b][t] <= DEF_HALF[b][(t < 16) ? t : 31 - t];
        end
      end
    end else if (wr && hit_coef) begin
      coef_r[page_bank][coef_tap] <=
        merge(coef_r[page_bank][coef_tap], hi_byte, wbyte);
    end
  end

  // active bank tap for the filter datapath
  wire logic [2:0] act_bank = fir_enable ? 3'(fir_bank - 3'h1) : 3'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coef_rd_data <= 16'h0000;
    end else begin
      coef_rd_data <= coef_r[act_bank][coef_rd_tap];
    end
  end

  // ----------------------------------------------------------------
  // read path; unmapped addresses read zero
  // ----------------------------------------------------------------
  wire logic [15:0] rd_word =
    hit_page ? {8'h00, page_r} :
    hit_fctl ? fctl_r :
    hit_sptr ? sptr_r :
    hit_ystat ? ystat_r :
    hit_zstat ? zstat_r :
    hit_ffreq ? ffreq_r :
    hit_cntlo ? fcnt_r[15:0] :
    hit_cnthi ? fcnt_r[31:16] :
    hit_coef ? coef_r[page_bank][coef_tap] :
    16'h0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 16'h0000;
    end else if (rd) begin
      dout <= rd_word;
    end
  end

endmodule : safcr_regs

`default_nettype wire

// ===== safcr_cfg.svh
// constants of the statistic, alarm and filter-coefficient register bank
`ifndef SAFCR_CFG_SVH
`define SAFCR_CFG_SVH

// ----------------------------------------------------------------
// register byte addresses (each register spans an even/odd pair)
// ----------------------------------------------------------------
`define SAFCR_ADDR_PAGE 7'h00
`define SAFCR_ADDR_FILTER_CONTROL 7'h1a
`define SAFCR_ADDR_STAT_PTR 7'h72
`define SAFCR_ADDR_Y_STAT 7'h76
`define SAFCR_ADDR_Z_STAT 7'h78
`define SAFCR_ADDR_FUNDAMENTAL_FREQUENCY 7'h7a
`define SAFCR_ADDR_FCNT_LO 7'h7c
`define SAFCR_ADDR_FCNT_HI 7'h7e
`define SAFCR_ADDR_COEF0 7'h08

// ----------------------------------------------------------------
// pages and field positions
// ----------------------------------------------------------------
`define SAFCR_PAGE_MAIN 8'h00
`define SAFCR_PAGE_BANK_FIRST 8'h01
`define SAFCR_PAGE_BANK_LAST 8'h06
`define SAFCR_DIN_WR_BIT 15
`define SAFCR_FCTL_BANK_LSB 0
`define SAFCR_FCTL_EN_BIT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SAFCR_RST_PAGE 8'h00
`define SAFCR_RST_FILTER_CONTROL 16'h0000
`define SAFCR_RST_STAT_PTR 16'h0000
`define SAFCR_RST_STAT 16'h0000
`define SAFCR_RST_FUNDAMENTAL_FREQUENCY 16'h0000
`define SAFCR_RST_FCNT 32'h0000_0000

// ----------------------------------------------------------------
// alarm band preload: edges in tenths of the fundamental, levels
// ----------------------------------------------------------------
`define SAFCR_EDGE_0 2
`define SAFCR_EDGE_1 8
`define SAFCR_EDGE_2 18
`define SAFCR_EDGE_3 28
`define SAFCR_EDGE_4 38
`define SAFCR_EDGE_5 102
`define SAFCR_ALM2_MG 500
`define SAFCR_ALM1_PCT_0 20
`define SAFCR_ALM1_PCT_1 90
`define SAFCR_ALM1_PCT_2 30
`define SAFCR_ALM1_PCT_3 25
`define SAFCR_ALM1_PCT_4 20
`define SAFCR_ALM1_PCT_5 15

`endif

// ===== safcr_pkg.sv
// types of the statistic, alarm and filter-coefficient register bank
package safcr_pkg;

  // metric codes held in the low bits of the statistic pointer
  typedef enum logic [2:0] {
    SAFCR_MEAN,
    SAFCR_STDDEV,
    SAFCR_PEAK,
    SAFCR_PEAK2PEAK,
    SAFCR_CREST,
    SAFCR_KURTOSIS,
    SAFCR_SKEWNESS,
    SAFCR_UNUSED
  } safcr_metric_t;

  typedef logic signed [15:0] safcr_coef_t;
  typedef logic [15:0] safcr_word_t;

endpackage : safcr_pkg

// ===== safcr_stat_fmt.sv
// formats one axis statistic result from the pointer and engine values
`timescale 1ns/1ps
`default_nettype none

module safcr_stat_fmt #(
  parameter int FIX_W = 24
) (
  input wire logic [7:0] ptr_lo,
  input wire logic [63:0] sample_words,
  input wire logic [3*FIX_W-1:0] fixed_vals,
  output logic [15:0] result
);

  initial begin
    if (FIX_W < 17) begin
      $error("safcr_stat_fmt: FIX_W must exceed 16 to flag overflow");
    end
  end

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  wire logic is_sample = (ptr_lo == 8'h00) || (ptr_lo == 8'h04) ||
                         (ptr_lo == 8'h05) || (ptr_lo == 8'h06);
  wire logic is_fixed = (ptr_lo == 8'h01) || (ptr_lo == 8'h02) ||
                        (ptr_lo == 8'h03);
  wire logic [1:0] s_idx = (ptr_lo == 8'h00) ? 2'h0 : 2'(ptr_lo[1:0] + 2'h1);
  wire logic [1:0] f_idx = 2'(ptr_lo[1:0] - 2'h1);
  wire logic [15:0] s_word = sample_words[s_idx*16 +: 16];
  wire logic [FIX_W-1:0] f_val = fixed_vals[f_idx*FIX_W +: FIX_W];

  // integer part above 255 saturates the whole word to ffff
  wire logic f_ovf = |f_val[FIX_W-1:16];
  wire logic [15:0] f_word = f_ovf ? 16'hffff : f_val[15:0];

  assign result = is_sample ? s_word :
                  is_fixed ? f_word :
                  16'h0000;

endmodule : safcr_stat_fmt

`default_nettype wire

// ===== safcr_regs_assertions.sv
// concurrent checks on the ports of the register bank
`timescale 1ns/1ps
`default_nettype none
`include "safcr_cfg.svh"

module safcr_regs_chk #(
  parameter int FMAX_DHZ = 1100000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din_valid,
  input wire logic [15:0] din,
  input wire logic [15:0] dout,
  input wire logic [2:0] stat_metric_sel,
  input wire logic flash_update_pulse,
  input wire logic alarm_load,
  input wire logic [6*24-1:0] band_start_dhz,
  input wire logic [6*24-1:0] band_stop_dhz,
  input wire logic [6*16-1:0] alarm1_level_mg,
  input wire logic [6*16-1:0] alarm2_level_mg,
  input wire logic fir_enable,
  input wire logic [2:0] fir_bank,
  input wire logic [15:0] flash_fundamental_frequency,
  input wire logic [15:0] flash_filter_control
);
  // ----------------------------------------------------------------
  // helper state: page and flash count seen at the ports
  // ----------------------------------------------------------------
  logic [7:0] page_r;
  logic [31:0] cnt_r;
  wire logic [6:0] adr = din[14:8];
  wire logic wr = din_valid && din[`SAFCR_DIN_WR_BIT];
  wire logic rd = din_valid && !din[`SAFCR_DIN_WR_BIT];
  wire logic main = page_r == `SAFCR_PAGE_MAIN;
  wire logic hi_wr = wr && main && adr == `SAFCR_ADDR_FUNDAMENTAL_FREQUENCY + 7'h1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_r <= `SAFCR_RST_PAGE;
      cnt_r <= `SAFCR_RST_FCNT;
    end else begin
      if (wr && adr == `SAFCR_ADDR_PAGE) page_r <= din[7:0];
      if (flash_update_pulse) cnt_r <= cnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_fund_load;
    hi_wr ##1 (flash_fundamental_frequency != 16'h0000);
  endsequence

  AST_LOAD_ON_HI: assert property (s_fund_load |-> alarm_load)
    else $error("no alarm load after nonzero upper write");
  AST_LOAD_CAUSE: assert property (alarm_load |-> $past(hi_wr) &&
    flash_fundamental_frequency != 16'h0000)
    else $error("alarm load without cause");
  AST_BANDS: assert property (alarm_load |->
    band_start_dhz[23:0] == 24'(`SAFCR_EDGE_0 * flash_fundamental_frequency) &&
    band_stop_dhz[143:120] == 24'(FMAX_DHZ) &&
    alarm1_level_mg[31:16] == 16'd450 && alarm2_level_mg[95:80] == 16'd500)
    else $error("band preload values wrong");
  AST_BAND_HOLD: assert property (!alarm_load |->
    $stable(band_start_dhz) && $stable(alarm1_level_mg))
    else $error("bands changed without load");
  AST_FIR_GATE: assert property (fir_bank == flash_filter_control[2:0] &&
    fir_enable == (flash_filter_control[3] && fir_bank >= 3'h1 && fir_bank <= 3'h6))
    else $error("filter enable or bank wrong");
  AST_PTR_SEL: assert property (
    wr && main && adr == `SAFCR_ADDR_STAT_PTR |=>
    stat_metric_sel == $past(din[2:0]))
    else $error("metric select does not follow pointer");
  AST_FUND_RD: assert property (
    rd && main && adr == `SAFCR_ADDR_FUNDAMENTAL_FREQUENCY |=> dout == flash_fundamental_frequency)
    else $error("fundamental read back wrong");
  AST_CNT_RD: assert property (
    rd && main && adr == `SAFCR_ADDR_FCNT_HI |=> dout == $past(cnt_r[31:16]))
    else $error("counter upper word wrong");
  AST_RO_WR: assert property (
    wr && main && adr[6:3] == 4'hf && adr[2:1] != 2'h1 |=>
    $stable(flash_fundamental_frequency) && !alarm_load)
    else $error("read-only write had an effect");
endmodule : safcr_regs_chk

bind safcr_regs safcr_regs_chk #(.FMAX_DHZ(FMAX_DHZ)) safcr_regs_chk_i (
  .clk(clk), .arst_n(arst_n), .din_valid(din_valid), .din(din),
  .dout(dout), .stat_metric_sel(stat_metric_sel),
  .flash_update_pulse(flash_update_pulse), .alarm_load(alarm_load),
  .band_start_dhz(band_start_dhz), .band_stop_dhz(band_stop_dhz),
  .alarm1_level_mg(alarm1_level_mg), .alarm2_level_mg(alarm2_level_mg),
  .fir_enable(fir_enable), .fir_bank(fir_bank),
  .flash_fundamental_frequency(flash_fundamental_frequency), .flash_filter_control(flash_filter_control)
);
`default_nettype wire

// ===== safcr_host.sv
// host model issuing byte writes and word reads on the command port
`timescale 1ns/1ps
`default_nettype none

module safcr_host (
  input wire logic clk,
  output logic din_valid,
  output logic [15:0] din,
  input wire logic [15:0] dout
);
  initial begin
    din_valid = 1'b0;
    din = 16'h0000;
  end

  // the word is scrambled once the strobe drops, so no stale value lingers
  task automatic send(input logic [15:0] cmd);
    @(posedge clk);
    din_valid <= 1'b1;
    din <= cmd;
    @(posedge clk);
    din_valid <= 1'b0;
    din <= ~cmd;
    #1;
  endtask : send

  task automatic wr_byte(input logic [6:0] a, input logic [7:0] b);
    send({1'b1, a, b});
  endtask : wr_byte

  task automatic rd_word(input logic [6:0] a, output logic [15:0] w);
    send({1'b0, a, 8'h00});
    @(posedge clk);
    #1;
    w = dout;
  endtask : rd_word
endmodule : safcr_host
`default_nettype wire

// ===== tb_safcr_regs.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
`include "safcr_cfg.svh"

`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
  end

module tb_safcr_regs;
  localparam int FMAX = 1100000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic din_valid;
  logic [15:0] din;
  logic [15:0] dout;
  logic [2:0] msel;
  logic [63:0] y_s = {16'h8444, 16'h8333, 16'h8222, 16'h8111};
  logic [63:0] z_s = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
  logic [71:0] y_f = {24'h000200, 24'h00069a, 24'h00000a};
  logic [71:0] z_f = {24'h012345, 24'h001af2, 24'h00016a};
  logic pulse = 1'b0;
  logic alarm_load;
  logic [143:0] b_start;
  logic [143:0] b_stop;
  logic [95:0] a1;
  logic [95:0] a2;
  logic fir_enable;
  logic [2:0] fir_bank;
  logic [4:0] tap = 5'h00;
  logic [15:0] coef;
  logic [15:0] ff;
  logic [15:0] fc;
  logic [15:0] w;
  logic [15:0] e;
  logic [15:0] z_exp [8] = '{16'h1111, 16'h016a, 16'h1af2, 16'hffff,
    16'h2222, 16'h3333, 16'h4444, 16'h0000};
  logic [15:0] y_exp [8] = '{16'h8111, 16'h000a, 16'h069a, 16'h0200,
    16'h8222, 16'h8333, 16'h8444, 16'h0000};
  logic [6:0] ro [6] = '{7'h78, 7'h79, 7'h7c, 7'h7d, 7'h7e, 7'h7f};
  int edg [7] = '{2, 8, 18, 28, 38, 102, 0};
  int pct [6] = '{20, 90, 30, 25, 20, 15};
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int loads = 0;

  always #2.5 clk = ~clk;

  safcr_regs #(.FIX_W(24), .FMAX_DHZ(FMAX)) safcr_regs_i (
    .clk(clk), .arst_n(arst_n), .din_valid(din_valid), .din(din),
    .dout(dout), .stat_metric_sel(msel), .y_stat_samples(y_s),
    .y_stat_fixed(y_f), .z_stat_samples(z_s), .z_stat_fixed(z_f),
    .flash_update_pulse(pulse), .alarm_load(alarm_load),
    .band_start_dhz(b_start), .band_stop_dhz(b_stop),
    .alarm1_level_mg(a1), .alarm2_level_mg(a2), .fir_enable(fir_enable),
    .fir_bank(fir_bank), .coef_rd_tap(tap), .coef_rd_data(coef),
    .flash_fundamental_frequency(ff), .flash_filter_control(fc)
  );

  safcr_host safcr_host_i (
    .clk(clk), .din_valid(din_valid), .din(din), .dout(dout)
  );

  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    if (alarm_load === 1'b1) loads++;
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    safcr_host_i.rd_word(`SAFCR_ADDR_FUNDAMENTAL_FREQUENCY, w);
    `CHK("fund rst", 16'h0000, w)
    safcr_host_i.rd_word(`SAFCR_ADDR_FCNT_HI, w);
    `CHK("fcnt hi rst", 16'h0000, w)
    for (int p = 0; p < 8; p++) begin
      safcr_host_i.wr_byte(`SAFCR_ADDR_STAT_PTR, 8'(p));
      `CHK("metric sel", 3'(p), msel)
      safcr_host_i.rd_word(`SAFCR_ADDR_Z_STAT, w);
      `CHK("z stat", z_exp[p], w)
      safcr_host_i.rd_word(`SAFCR_ADDR_Y_STAT, w);
      `CHK("y stat", y_exp[p], w)
    end
    safcr_host_i.wr_byte(`SAFCR_ADDR_STAT_PTR, 8'h01);
    foreach (ro[i]) safcr_host_i.wr_byte(ro[i], 8'h5a);
    safcr_host_i.rd_word(`SAFCR_ADDR_Z_STAT, w);
    `CHK("z after ro write", 16'h016a, w)
    safcr_host_i.rd_word(`SAFCR_ADDR_FCNT_LO, w);
    `CHK("fcnt lo after ro write", 16'h0000, w)
    safcr_host_i.rd_word(7'h40, w);
    `CHK("unmapped read", 16'h0000, w)
    safcr_host_i.wr_byte(`SAFCR_ADDR_FUNDAMENTAL_FREQUENCY, 8'h64);
    safcr_host_i.wr_byte(`SAFCR_ADDR_FUNDAMENTAL_FREQUENCY + 7'h1, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    `CHK("load count", 1, loads)
    `CHK("fund store", 16'h0164, ff)
    for (int i = 0; i < 6; i++) begin
      `CHK("start", 24'(edg[i] * 356), b_start[i*24+:24])
      `CHK("stop", (i == 5) ? 24'(FMAX) : 24'(edg[i+1] * 356),
        b_stop[i*24+:24])
      `CHK("alarm1", 16'(5 * pct[i]), a1[i*16+:16])
      `CHK("alarm2", 16'd500, a2[i*16+:16])
    end
    safcr_host_i.wr_byte(`SAFCR_ADDR_FUNDAMENTAL_FREQUENCY, 8'h00);
    safcr_host_i.wr_byte(`SAFCR_ADDR_FUNDAMENTAL_FREQUENCY + 7'h1, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("zero no load", 1, loads)
    `CHK("bands kept", 24'(712), b_start[23:0])
    @(posedge clk);
    pulse <= 1'b1;
    repeat (65537) @(posedge clk);
    pulse <= 1'b0;
    safcr_host_i.rd_word(`SAFCR_ADDR_FCNT_LO, w);
    `CHK("fcnt lo", 16'h0001, w)
    safcr_host_i.rd_word(`SAFCR_ADDR_FCNT_HI, w);
    `CHK("fcnt hi", 16'h0001, w)
    safcr_host_i.wr_byte(`SAFCR_ADDR_PAGE, 8'h03);
    safcr_host_i.rd_word(`SAFCR_ADDR_PAGE, w);
    `CHK("page", 16'h0003, w)
    for (int k = 0; k < 32; k++) begin
      e = 16'h0400 - 16'(k == 31);
      safcr_host_i.wr_byte(`SAFCR_ADDR_COEF0 + 7'(2 * k), e[7:0]);
      safcr_host_i.wr_byte(`SAFCR_ADDR_COEF0 + 7'(2 * k + 1), e[15:8]);
    end
    for (int k = 0; k < 32; k++) begin
      safcr_host_i.rd_word(`SAFCR_ADDR_COEF0 + 7'(2 * k), w);
      `CHK("coef", 16'h0400 - 16'(k == 31), w)
    end
    safcr_host_i.wr_byte(`SAFCR_ADDR_PAGE, 8'h04);
    safcr_host_i.rd_word(`SAFCR_ADDR_COEF0 + 7'd10, w);
    safcr_host_i.rd_word(`SAFCR_ADDR_COEF0 + 7'd52, e);
    `CHK("default symmetry", w, e)
    safcr_host_i.wr_byte(`SAFCR_ADDR_PAGE, 8'h00);
    safcr_host_i.wr_byte(`SAFCR_ADDR_FILTER_CONTROL, 8'h0b);
    `CHK("fir en", 1'b1, fir_enable)
    `CHK("fir bank", 3'h3, fir_bank)
    `CHK("filt store", 16'h000b, fc)
    @(posedge clk);
    tap <= 5'd31;
    @(posedge clk);
    #1;
    `CHK("coef datapath", 16'h03ff, coef)
    safcr_host_i.wr_byte(`SAFCR_ADDR_FILTER_CONTROL, 8'h0f);
    `CHK("fir en bank7", 1'b0, fir_enable)
    safcr_host_i.wr_byte(`SAFCR_ADDR_FILTER_CONTROL, 8'h03);
    `CHK("fir off", 1'b0, fir_enable)
    print_verdict();
  end
endmodule : tb_safcr_regs
`default_nettype wire
